// file: rtl/tca_pkg.sv
// package: constants and carriers for the compare/capture timer contention block
package tca_pkg;
  // count source select codes (3 bits)
  localparam logic [2:0] SRC_FAST     = 3'h6;
  localparam logic [2:0] SRC_EXT      = 3'h7;
  // divider ratios for internal sources: codes 0..5 -> 2,2,4,8,32,32
  localparam int         DIV_W        = 5;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] GR_RST      = 16'hffff;
  localparam int         NUM_GR       = 4;
  // fast clock enable period in core clocks
  localparam int         FAST_DIV     = 3;
  // output action per channel: 0 none, 1 low, 2 high, 3 toggle
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_LOW      = 2'h1;
  localparam logic [1:0] ACT_HIGH     = 2'h2;
  localparam logic [1:0] ACT_TOGGLE   = 2'h3;

  // first control register write carrier
  typedef struct packed {
    logic       wr;
    logic       clear_on_a;
    logic [2:0] count_source_select;
    logic [3:0] initial_pin_levels;
  } tca_ctrl_s;

  // counter write carrier
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } tca_cntwr_s;
endpackage : tca_pkg

// file: rtl/tca_timer.sv
// timer counter with write, clear, count and compare contention handling
//
// Function
// - a counter write is committed in the second cycle of its write, not the first.
// - a counter clear in the commit cycle wins and the written value is dropped.
// - a counter write that meets a count-up loads the value and the increment is lost.
// - internal count pulses come from rising edges of the selected divided clock, even one made by switching.
// - entering module standby leaves a pending request uncleared.
// - compare pins show the initial levels until the first compare match changes them.
// - a first control register write in the match cycle is applied and the match's pin change is dropped.
// - a compare match fires when the counter leaves the matching value on the next count.
// - a status flag clears only on a zero write after it was read as one.
`timescale 1ns/100ps
module tca_timer (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 count_enable,
  input  wire logic                 module_standby,
  input  wire tca_pkg::tca_ctrl_s   ctrl_in,
  input  wire tca_pkg::tca_cntwr_s  cnt_wr,
  input  wire logic [63:0]          general_match_regs,
  input  wire logic [7:0]           match_actions,
  input  wire logic                 ext_clk_in,
  input  wire logic [3:0]           flag_read,
  input  wire logic [3:0]           flag_write_zero,
  output logic [15:0]               timer_count_value,
  output logic [3:0]                compare_capture_pins,
  output logic [3:0]                compare_capture_oe,
  output logic [3:0]                match_flags,
  output logic [3:0]                initial_pin_levels,
  output logic [2:0]                count_source_select,
  output logic                      irq_pending
);

  // ************************************
  // state
  // ************************************
  localparam int    DIV_LEN = tca_pkg::DIV_W;
  logic [15:0]      cnt_q;
  logic [DIV_LEN-1:0] div_q;
  logic             src_lvl_q;
  logic             ext_q;
  logic [1:0]       fast_q;
  logic             wr_pend_q;
  logic [15:0]      wr_data_q;
  logic             clr_on_a_q;
  logic [2:0]       sel_q;
  logic [3:0]       init_q;
  logic [3:0]       pin_q;
  logic [3:0]       eq_q;
  logic [3:0]       flag_q;
  logic [3:0]       seen_q;

  // selected divided level for a source code
  function automatic logic div_level(input logic [2:0] sel, input logic [DIV_LEN-1:0] d, input logic [1:0] f);
    unique case (sel)
      3'h0:    div_level = d[0] ^ 1'b1;
      3'h1:    div_level = d[0];
      3'h2:    div_level = d[1];
      3'h3:    div_level = d[2];
      3'h4:    div_level = d[4];
      3'h5:    div_level = d[4];
      3'h6:    div_level = (f == 2'h0);
      default: div_level = 1'b0;
    endcase
  endfunction : div_level

  // ************************************
  // count pulse generation
  // ************************************
  logic cur_lvl;
  logic cnt_pulse;
  logic clr_evt;
  logic commit;
  logic [3:0] match;
  logic ctrl_hit;

  assign cur_lvl = (sel_q == tca_pkg::SRC_EXT) ? ext_q : div_level(sel_q, div_q, fast_q);
  // with count_enable high, any low-to-high of the chosen level counts, switch-made ones too
  assign cnt_pulse = count_enable & cur_lvl & ~src_lvl_q;

  // free-running prescaler and fast-clock enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q  <= '0;
      fast_q <= 2'h0;
    end else begin
      div_q  <= div_q + DIV_LEN'(1);
      fast_q <= (fast_q == 2'(tca_pkg::FAST_DIV - 1)) ? 2'h0 : fast_q + 2'h1;
    end
  end

  // previous source level and external pin sample
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      src_lvl_q <= 1'b0;
      ext_q     <= 1'b0;
    end else begin
      src_lvl_q <= cur_lvl;
      ext_q     <= ext_clk_in;
    end
  end

  // ************************************
  // compare and counter
  // ************************************
  // match when leaving an equal value on a count
  always_comb begin
    for (int i = 0; i < tca_pkg::NUM_GR; i++) begin
      match[i] = eq_q[i] & cnt_pulse;
    end
  end
  assign clr_evt = clr_on_a_q & match[0];
  assign commit  = wr_pend_q;
  assign ctrl_hit = ctrl_in.wr;

  // equality held per general register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eq_q <= 4'h0;
    end else begin
      for (int i = 0; i < tca_pkg::NUM_GR; i++) begin
        eq_q[i] <= (cnt_q == general_match_regs[16*i +: 16]);
      end
    end
  end

  // write taken in first cycle, committed in the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_data_q <= tca_pkg::CNT_RST;
    end else begin
      wr_pend_q <= cnt_wr.wr;
      if (cnt_wr.wr) begin
        wr_data_q <= cnt_wr.data;
      end
    end
  end

  // clear beats write, write beats count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= tca_pkg::CNT_RST;
    end else if (clr_evt) begin
      cnt_q <= tca_pkg::CNT_RST;
    end else if (commit) begin
      cnt_q <= wr_data_q;
    end else if (cnt_pulse) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ************************************
  // control register
  // ************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clr_on_a_q <= 1'b0;
      sel_q      <= 3'h0;
      init_q     <= 4'h0;
    end else if (ctrl_in.wr) begin
      clr_on_a_q <= ctrl_in.clear_on_a;
      sel_q      <= ctrl_in.count_source_select;
      init_q     <= ctrl_in.initial_pin_levels;
    end
  end

  // ************************************
  // compare pins
  // ************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_q <= 4'h0;
    end else if (ctrl_hit) begin
      pin_q <= ctrl_in.initial_pin_levels;
    end else begin
      for (int i = 0; i < tca_pkg::NUM_GR; i++) begin
        if (match[i]) begin
          unique case (match_actions[2*i +: 2])
            tca_pkg::ACT_LOW:    pin_q[i] <= 1'b0;
            tca_pkg::ACT_HIGH:   pin_q[i] <= 1'b1;
            tca_pkg::ACT_TOGGLE: pin_q[i] <= ~pin_q[i];
            tca_pkg::ACT_NONE:   pin_q[i] <= pin_q[i];
          endcase
        end
      end
    end
  end

  // ************************************
  // status flags
  // ************************************
  // set wins; clear needs a prior read-as-one; standby freezes them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 4'h0;
      seen_q <= 4'h0;
    end else if (!module_standby) begin
      for (int i = 0; i < tca_pkg::NUM_GR; i++) begin
        if (match[i]) begin
          flag_q[i] <= 1'b1;
        end else if (flag_write_zero[i] && seen_q[i]) begin
          flag_q[i] <= 1'b0;
        end
        if (flag_read[i]) begin
          seen_q[i] <= flag_q[i];
        end else if (flag_write_zero[i]) begin
          seen_q[i] <= 1'b0;
        end
      end
    end
  end

  // outputs
  assign timer_count_value    = cnt_q;
  assign compare_capture_pins = pin_q;
  assign compare_capture_oe   = 4'hf;
  assign match_flags          = flag_q;
  assign initial_pin_levels   = init_q;
  assign count_source_select  = sel_q;
  assign irq_pending          = |flag_q;
endmodule : tca_timer

// file: tb/tca_timer_properties.sv
// checker: port-level properties of the timer contention block
`timescale 1ns/100ps
module tca_timer_properties (
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                module_standby,
  input wire tca_pkg::tca_ctrl_s  ctrl_in,
  input wire tca_pkg::tca_cntwr_s cnt_wr,
  input wire logic [63:0]         general_match_regs,
  input wire logic [3:0]          flag_write_zero,
  input wire logic [15:0]         timer_count_value,
  input wire logic [3:0]          compare_capture_pins,
  input wire logic [3:0]          compare_capture_oe,
  input wire logic [3:0]          match_flags,
  input wire logic [3:0]          initial_pin_levels,
  input wire logic [2:0]          count_source_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] general_match_register_a;
  // channel a compare value, the only one that can clear
  assign general_match_register_a = general_match_regs[15:0];
  AST_WR_COMMIT: assert property (cnt_wr.wr && timer_count_value != general_match_register_a
    ##1 timer_count_value != general_match_register_a
    |=> timer_count_value == $past(cnt_wr.data, 2)) else $error("counter write not loaded");
  AST_COUNT_STEP: assert property ($changed(timer_count_value) && !$past(cnt_wr.wr, 2)
    && timer_count_value != 16'h0000 |-> timer_count_value == $past(timer_count_value) + 16'h0001)
    else $error("counter step not one");
  AST_STBY_FREEZE: assert property ($past(module_standby) |-> $stable(match_flags))
    else $error("flags moved in standby");
  AST_FLAG_CLR: assert property (!(|($past(match_flags) & ~match_flags & ~$past(flag_write_zero))))
    else $error("flag fell without write");
  AST_MATCH_LEAVE: assert property ($rose(match_flags[0])
    |-> $past(timer_count_value, 2) == general_match_register_a
    || $past(timer_count_value, 3) == general_match_register_a) else $error("early match");
  AST_CTRL_PINS: assert property (ctrl_in.wr |=> compare_capture_pins == $past(ctrl_in.initial_pin_levels))
    else $error("pins not reloaded");
  AST_CTRL_CFG: assert property (ctrl_in.wr |=> initial_pin_levels == $past(ctrl_in.initial_pin_levels)
    && count_source_select == $past(ctrl_in.count_source_select)) else $error("control not applied");
  AST_PIN_DRIVE: assert property (compare_capture_oe == 4'hf) else $error("pins not driven");
  COV_WR: cover property (cnt_wr.wr ##2 timer_count_value == $past(cnt_wr.data, 2));
  COV_MATCH: cover property ($rose(match_flags[0]));
  COV_CLR: cover property ($fell(match_flags[0]));
endmodule : tca_timer_properties
bind tca_timer tca_timer_properties tca_timer_properties_i (.*);

// file: tb/tca_ext_src.sv
// far-side model: external count clock pin
`timescale 1ns/100ps
module tca_ext_src (
  input  wire logic core_clk,
  output logic      ext_clk_in
);
  initial ext_clk_in = 1'h0;
  // each level held four clocks, above the three-clock minimum
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      #1 ext_clk_in = 1'h1;
      repeat (4) @(posedge core_clk);
      #1 ext_clk_in = 1'h0;
    end
  endtask : pulse
endmodule : tca_ext_src

// file: tb/tb_tca_timer.sv
// testbench: counter write, compare output and flag scenarios
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_tca_timer;
  logic core_clk = 1'h0, rst = 1'h1, count_enable = 1'h0, module_standby = 1'h0, ext_clk_in, irq_pending;
  tca_pkg::tca_ctrl_s  ctrl_in = '0;
  tca_pkg::tca_cntwr_s cnt_wr = '0;
  logic [63:0]         general_match_regs = 64'hffff_ffff_ffff_1236;
  logic [7:0]          match_actions = 8'h03;
  logic [3:0]          flag_read = 4'h0, flag_write_zero = 4'h0;
  logic [3:0]          compare_capture_pins, compare_capture_oe, match_flags, initial_pin_levels;
  logic [15:0]         timer_count_value;
  logic [2:0]          count_source_select;
  int                  error_cnt = 0, n_checks = 0;
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  tca_timer tca_timer_i (.*);
  tca_ext_src tca_ext_src_i (.*);
  // wait n edges, then step off the edge
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // optional read, then write zero to flag 0
  task clr(input logic rd);
    flag_read = {3'h0, rd};
    tick(1);
    flag_read = 4'h0;
    flag_write_zero = 4'h1;
    tick(1);
    flag_write_zero = 4'h0;
    tick(1);
  endtask : clr
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // watchdog, far beyond the hundred or so cycles of the tests
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end
  // test sequence
  initial begin
    tick(8);
    rst = 1'h0;
    tick(1);
    `CHK(compare_capture_oe, 4'hf)
    cnt_wr = '{1'h1, 16'h1234};
    tick(1);
    cnt_wr.wr = 1'h0;
    `CHK(timer_count_value, 16'h0000)
    tick(1);
    `CHK(timer_count_value, 16'h1234)
    $display("test write done");
    ctrl_in = '{1'h1, 1'h0, tca_pkg::SRC_EXT, 4'ha};
    tick(1);
    ctrl_in.wr = 1'h0;
    `CHK(compare_capture_pins, 4'ha)
    `CHK(count_source_select, tca_pkg::SRC_EXT)
    count_enable = 1'h1;
    tca_ext_src_i.pulse(2);
    tick(3);
    `CHK(timer_count_value, 16'h1236)
    tca_ext_src_i.pulse(1);
    tick(3);
    `CHK(match_flags, 4'h1)
    `CHK(compare_capture_pins, 4'hb)
    $display("test compare done");
    clr(1'h0);
    `CHK(match_flags, 4'h1)
    module_standby = 1'h1;
    clr(1'h1);
    `CHK(irq_pending, 1'h1)
    module_standby = 1'h0;
    clr(1'h1);
    `CHK(match_flags, 4'h0)
    $display("test flags done");
    // write meeting a count-up: value loads, increment lost
    fork
      tca_ext_src_i.pulse(1);
      begin
        tick(4);
        cnt_wr = '{1'h1, 16'h0100};
        tick(1);
        cnt_wr.wr = 1'h0;
      end
    join
    `CHK(timer_count_value, 16'h0100)
    // stop, copy pin levels into the initial bits, restart
    count_enable = 1'h0;
    ctrl_in = '{1'h1, 1'h1, tca_pkg::SRC_EXT, compare_capture_pins};
    tick(1);
    ctrl_in.wr = 1'h0;
    `CHK(compare_capture_pins, 4'hb)
    count_enable = 1'h1;
    // clear from match a in the commit cycle drops the write
    cnt_wr = '{1'h1, 16'h1236};
    tick(1);
    cnt_wr.wr = 1'h0;
    tick(2);
    fork
      tca_ext_src_i.pulse(1);
      begin
        tick(4);
        cnt_wr = '{1'h1, 16'h0055};
        tick(1);
        cnt_wr.wr = 1'h0;
      end
    join
    `CHK(timer_count_value, 16'h0000)
    `CHK(match_flags, 4'h1)
    `CHK(compare_capture_pins, 4'ha)
    // control write in the match cycle wins over the toggle
    cnt_wr = '{1'h1, 16'h1236};
    tick(1);
    cnt_wr.wr = 1'h0;
    tick(2);
    fork
      tca_ext_src_i.pulse(1);
      begin
        tick(5);
        ctrl_in = '{1'h1, 1'h0, tca_pkg::SRC_EXT, 4'h5};
        tick(1);
        ctrl_in.wr = 1'h0;
      end
    join
    `CHK(compare_capture_pins, 4'h5)
    $display("test contention done");
    // fast source: one idle slot between a write and the next read
    count_enable = 1'h0;
    ctrl_in = '{1'h1, 1'h0, tca_pkg::SRC_FAST, 4'h5};
    tick(1);
    ctrl_in.wr = 1'h0;
    cnt_wr = '{1'h1, 16'h0200};
    tick(1);
    cnt_wr.wr = 1'h0;
    tick(1);
    `CHK(count_source_select, tca_pkg::SRC_FAST)
    `CHK(timer_count_value, 16'h0200)
    count_enable = 1'h1;
    tick(30);
    `CHK(timer_count_value, 16'h020a)
    $display("test fast clock done");
    print_verdict();
  end
endmodule : tb_tca_timer
